//--- include/dsgate_params.svh
`ifndef DSGATE_PARAMS_SVH
`define DSGATE_PARAMS_SVH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define DSG_GATE_OFFSET     12'h124
`define DSG_RUN_OFFSET      12'h200
`define DSG_CONFIG_OFFSET   12'h204
`define DSG_INT_STAT_OFFSET 12'h208
`define DSG_INT_CLR_OFFSET  12'h20C
`define DSG_INT_EN_OFFSET   12'h210
`define DSG_FAULT_OFFSET    12'h214

// ----------------------------------------------------------------------
// Gate register field positions
// ----------------------------------------------------------------------
`define DSG_CMP_2_BIT       26
`define DSG_CMP_1_BIT       25
`define DSG_CMP_0_BIT       24
`define DSG_TMR_3_BIT       19
`define DSG_TMR_2_BIT       18
`define DSG_TMR_1_BIT       17
`define DSG_TMR_0_BIT       16
`define DSG_TWO_WIRE_BIT    12
`define DSG_QUAD_ENC_BIT    8
`define DSG_SYNC1_BIT       5
`define DSG_SYNC0_BIT       4
`define DSG_GATE_MASK       32'h070F_1130

// ----------------------------------------------------------------------
// Other fields and reset values
// ----------------------------------------------------------------------
`define DSG_AUTO_GATE_BIT   0
`define DSG_INT_FAULT_BIT   0
`define DSG_INT_SLEEP_BIT   1
`define DSG_INT_WIDTH       2
`define DSG_GATE_RESET      32'h0000_0000
`define DSG_RUN_RESET       32'h0000_0000
`define DSG_PERIPH_COUNT    11

`endif

//--- include/dsgate_pkg.sv
package dsgate_pkg;

  // Per-peripheral clock enables, most significant field first
  typedef struct packed {
    logic comparator_two_clock_enable;
    logic comparator_one_clock_enable;
    logic comparator_zero_clock_enable;
    logic gp_timer_three_clock_enable;
    logic gp_timer_two_clock_enable;
    logic gp_timer_one_clock_enable;
    logic gp_timer_zero_clock_enable;
    logic two_wire_zero_clock_enable;
    logic quadrature_encoder_clock_enable;
    logic sync_serial_one_clock_enable;
    logic sync_serial_zero_clock_enable;
  } periph_gate_t;

  // Result of checking one peripheral access
  typedef struct packed {
    logic       grant;
    logic       fault;
    logic [3:0] index;
  } access_result_t;

  typedef enum logic {
    RUN_MODE,
    DEEP_SLEEP_MODE
  } power_mode_t;

endpackage : dsgate_pkg

//--- hw/periph_access_check.sv
`timescale 1ns/1ps

module periph_access_check #(
  parameter int NUM_PERIPH = 11
) (
  // Gate settings
  input  wire dsgate_pkg::periph_gate_t    ds_gate_i,
  input  wire dsgate_pkg::periph_gate_t    run_gate_i,
  input  wire logic                        deep_sleep_i,
  input  wire logic                        auto_clock_gating_select_i,
  // Peripheral access request
  input  wire logic                        req_i,
  input  wire logic [NUM_PERIPH-1:0]       sel_i,
  // Results
  output dsgate_pkg::periph_gate_t         eff_gate_o,
  output dsgate_pkg::access_result_t       result_o
);

  if (NUM_PERIPH != $bits(dsgate_pkg::periph_gate_t)) begin : g_bad_count
    $error("NUM_PERIPH must match the gate vector width");
  end

  logic [NUM_PERIPH-1:0] blocked;
  logic [3:0]            first_idx;

  // Deep-sleep gates rule only in deep-sleep with auto clock gating selected
  assign eff_gate_o = (deep_sleep_i && auto_clock_gating_select_i)
                      ? ds_gate_i : run_gate_i;              // [RULE_11]

  // An access to an unclocked peripheral is refused
  assign blocked = sel_i & ~eff_gate_o;                      // [RULE_07]

  always_comb begin
    first_idx = 4'h0;
    for (int i = NUM_PERIPH - 1; i >= 0; i--) begin
      if (blocked[i]) begin
        first_idx = 4'(i);
      end
    end
  end

  assign result_o.fault = req_i && (|blocked);               // [RULE_07]
  assign result_o.grant = req_i && (|sel_i) && !(|blocked);
  assign result_o.index = first_idx;

endmodule : periph_access_check

//--- hw/deep_sleep_clock_gating.sv
// Operation
// (RULE_01) Bits 19..16 are writable gates for timers three down to zero.
// (RULE_02) Bits 26..24 are writable gates for comparators two down to zero.
// (RULE_03) Bit 12 is the writable gate for the two-wire serial module.
// (RULE_04) Bit 8 is the writable gate for the quadrature encoder.
// (RULE_05) Bits 5 and 4 gate synchronous serial modules one and zero.
// (RULE_06) A set gate clocks its peripheral; a clear gate stops it.
// (RULE_07) Access to an unclocked peripheral returns a bus fault.
// (RULE_08) Reserved bits read zero and ignore writes.
// (RULE_09) Software uses read-modify-write and ignores reserved contents.
// (RULE_10) All gate bits reset to zero, every peripheral unclocked.
// (RULE_11) Deep-sleep gates apply only in deep-sleep with auto gating on.
// (RULE_12) A write updates the gates at once; reads return stored gates.
`timescale 1ns/1ps
`include "dsgate_params.svh"

module deep_sleep_clock_gating #(
  parameter int NUM_PERIPH = `DSG_PERIPH_COUNT,
  parameter int ADDR_WIDTH = 12
) (
  // Clock, reset, enable
  input  wire logic                        CLOCK_I,
  input  wire logic                        SRST_I,
  input  wire logic                        CE_I,
  // APB slave
  input  wire logic                        PSEL_I,
  input  wire logic                        PENABLE_I,
  input  wire logic                        PWRITE_I,
  input  wire logic [ADDR_WIDTH-1:0]       PADDR_I,
  input  wire logic [31:0]                 PWDATA_I,
  output logic                             PREADY_O,
  output logic [31:0]                      PRDATA_O,
  output logic                             PSLVERR_O,
  // Power state
  input  wire logic                        DEEP_SLEEP_I,
  // Peripheral access check
  input  wire logic                        PERIPH_REQ_I,
  input  wire logic [NUM_PERIPH-1:0]       PERIPH_SEL_I,
  output logic                             PERIPH_GRANT_O,
  output logic                             PERIPH_FAULT_O,
  // Peripheral clock enables and interrupt
  output dsgate_pkg::periph_gate_t         CLOCK_ENABLE_O,
  output logic                             IRQ_O
);

  // --------------------------------------------------------------------
  // Elaboration checks
  // --------------------------------------------------------------------
  if (NUM_PERIPH != `DSG_PERIPH_COUNT) begin : g_bad_count
    $error("NUM_PERIPH must equal the number of gate fields");
  end
  if (ADDR_WIDTH < 12) begin : g_bad_addr
    $error("ADDR_WIDTH too small for the register map");
  end

  // --------------------------------------------------------------------
  // Field mapping
  // --------------------------------------------------------------------
  function automatic dsgate_pkg::periph_gate_t reg_to_gate(
    input logic [31:0] w
  );
    dsgate_pkg::periph_gate_t g;
    g.comparator_two_clock_enable     = w[`DSG_CMP_2_BIT];    // [RULE_02]
    g.comparator_one_clock_enable     = w[`DSG_CMP_1_BIT];
    g.comparator_zero_clock_enable    = w[`DSG_CMP_0_BIT];
    g.gp_timer_three_clock_enable     = w[`DSG_TMR_3_BIT];    // [RULE_01]
    g.gp_timer_two_clock_enable       = w[`DSG_TMR_2_BIT];
    g.gp_timer_one_clock_enable       = w[`DSG_TMR_1_BIT];
    g.gp_timer_zero_clock_enable      = w[`DSG_TMR_0_BIT];
    g.two_wire_zero_clock_enable      = w[`DSG_TWO_WIRE_BIT]; // [RULE_03]
    g.quadrature_encoder_clock_enable = w[`DSG_QUAD_ENC_BIT]; // [RULE_04]
    g.sync_serial_one_clock_enable    = w[`DSG_SYNC1_BIT];    // [RULE_05]
    g.sync_serial_zero_clock_enable   = w[`DSG_SYNC0_BIT];
    return g;
  endfunction : reg_to_gate

  // Bits outside the gate fields stay zero
  function automatic logic [31:0] gate_to_reg(
    input dsgate_pkg::periph_gate_t g
  );
    logic [31:0] w;
    w                    = 32'h0000_0000;                     // [RULE_08]
    w[`DSG_CMP_2_BIT]    = g.comparator_two_clock_enable;
    w[`DSG_CMP_1_BIT]    = g.comparator_one_clock_enable;
    w[`DSG_CMP_0_BIT]    = g.comparator_zero_clock_enable;
    w[`DSG_TMR_3_BIT]    = g.gp_timer_three_clock_enable;
    w[`DSG_TMR_2_BIT]    = g.gp_timer_two_clock_enable;
    w[`DSG_TMR_1_BIT]    = g.gp_timer_one_clock_enable;
    w[`DSG_TMR_0_BIT]    = g.gp_timer_zero_clock_enable;
    w[`DSG_TWO_WIRE_BIT] = g.two_wire_zero_clock_enable;
    w[`DSG_QUAD_ENC_BIT] = g.quadrature_encoder_clock_enable;
    w[`DSG_SYNC1_BIT]    = g.sync_serial_one_clock_enable;
    w[`DSG_SYNC0_BIT]    = g.sync_serial_zero_clock_enable;
    return w;
  endfunction : gate_to_reg

  // --------------------------------------------------------------------
  // State
  // --------------------------------------------------------------------
  dsgate_pkg::periph_gate_t   ds_gate;
  dsgate_pkg::periph_gate_t   next_ds_gate;
  dsgate_pkg::periph_gate_t   run_gate;
  dsgate_pkg::periph_gate_t   next_run_gate;
  dsgate_pkg::periph_gate_t   eff_gate;
  dsgate_pkg::periph_gate_t   next_clock_enable;
  dsgate_pkg::access_result_t access;
  dsgate_pkg::power_mode_t    mode;
  dsgate_pkg::power_mode_t    next_mode;
  logic                       auto_clock_gating_select;
  logic                       next_auto_clock_gating_select;
  logic [`DSG_INT_WIDTH-1:0]  int_stat;
  logic [`DSG_INT_WIDTH-1:0]  next_int_stat;
  logic [`DSG_INT_WIDTH-1:0]  int_en;
  logic [`DSG_INT_WIDTH-1:0]  next_int_en;
  logic [`DSG_INT_WIDTH-1:0]  int_set;
  logic [`DSG_INT_WIDTH-1:0]  int_clr;
  logic [3:0]                 fault_idx;
  logic [3:0]                 next_fault_idx;
  logic                       next_pready;
  logic [31:0]                next_prdata;
  logic                       next_pslverr;
  logic                       next_grant;
  logic                       next_fault;
  logic                       next_irq;
  logic                       setup;
  logic                       wr_en;
  logic [11:0]                addr;
  logic                       mapped;

  assign addr  = PADDR_I[11:0];
  assign setup = PSEL_I && !PENABLE_I;
  // Write takes effect at the completing edge of the access phase
  assign wr_en = PSEL_I && PENABLE_I && PREADY_O && PWRITE_I &&
                 (PADDR_I[ADDR_WIDTH-1:0] == ADDR_WIDTH'(addr));

  // --------------------------------------------------------------------
  // Access checker
  // --------------------------------------------------------------------
  periph_access_check #(
    .NUM_PERIPH (NUM_PERIPH)
  ) u_check (
    .ds_gate_i    (ds_gate),
    .run_gate_i   (run_gate),
    .deep_sleep_i (mode == dsgate_pkg::DEEP_SLEEP_MODE),
    .auto_clock_gating_select_i (auto_clock_gating_select),
    .req_i        (PERIPH_REQ_I),
    .sel_i        (PERIPH_SEL_I),
    .eff_gate_o   (eff_gate),
    .result_o     (access)
  );

  // --------------------------------------------------------------------
  // Register file
  // --------------------------------------------------------------------
  always_comb begin
    next_ds_gate  = ds_gate;
    next_run_gate = run_gate;
    next_auto_clock_gating_select = auto_clock_gating_select;
    next_int_en   = int_en;
    int_clr       = '0;
    if (wr_en) begin
      case (addr)
        `DSG_GATE_OFFSET:    next_ds_gate  = reg_to_gate(PWDATA_I); // [RULE_12]
        `DSG_RUN_OFFSET:     next_run_gate = reg_to_gate(PWDATA_I);
        `DSG_CONFIG_OFFSET:  next_auto_clock_gating_select =
                               PWDATA_I[`DSG_AUTO_GATE_BIT];
        `DSG_INT_CLR_OFFSET: int_clr = PWDATA_I[`DSG_INT_WIDTH-1:0];
        `DSG_INT_EN_OFFSET:  next_int_en = PWDATA_I[`DSG_INT_WIDTH-1:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      ds_gate                  <= reg_to_gate(`DSG_GATE_RESET); // [RULE_10]
      run_gate                 <= reg_to_gate(`DSG_RUN_RESET);
      auto_clock_gating_select <= 1'b0;
      int_en   <= '0;
    end else if (CE_I) begin
      ds_gate  <= next_ds_gate;
      run_gate <= next_run_gate;
      auto_clock_gating_select <= next_auto_clock_gating_select;
      int_en   <= next_int_en;
    end
  end

  // --------------------------------------------------------------------
  // APB answer
  // --------------------------------------------------------------------
  always_comb begin
    mapped      = 1'b1;
    next_prdata = 32'h0000_0000;
    case (addr)
      `DSG_GATE_OFFSET:     next_prdata = gate_to_reg(ds_gate); // [RULE_12]
      `DSG_RUN_OFFSET:      next_prdata = gate_to_reg(run_gate);
      `DSG_CONFIG_OFFSET:   next_prdata[`DSG_AUTO_GATE_BIT] =
                              auto_clock_gating_select;
      `DSG_INT_STAT_OFFSET: next_prdata[`DSG_INT_WIDTH-1:0] = int_stat;
      `DSG_INT_CLR_OFFSET:  next_prdata = 32'h0000_0000;
      `DSG_INT_EN_OFFSET:   next_prdata[`DSG_INT_WIDTH-1:0] = int_en;
      `DSG_FAULT_OFFSET:    next_prdata[3:0] = fault_idx;
      default:              mapped = 1'b0;
    endcase
    if (PADDR_I[ADDR_WIDTH-1:0] != ADDR_WIDTH'(addr)) begin
      mapped = 1'b0;
    end
    if (!mapped || PWRITE_I) begin
      next_prdata = 32'h0000_0000;
    end
    next_pready  = setup;
    next_pslverr = setup && !mapped;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      PREADY_O  <= 1'b0;
      PRDATA_O  <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (CE_I) begin
      PREADY_O  <= next_pready;
      PRDATA_O  <= next_prdata;
      PSLVERR_O <= next_pslverr;
    end
  end

  // --------------------------------------------------------------------
  // Mode, clock enables and peripheral access
  // --------------------------------------------------------------------
  always_comb begin
    next_mode = DEEP_SLEEP_I ? dsgate_pkg::DEEP_SLEEP_MODE
                             : dsgate_pkg::RUN_MODE;
    next_clock_enable = eff_gate;                             // [RULE_06]
    next_grant        = access.grant;
    next_fault        = access.fault;                         // [RULE_07]
    next_fault_idx    = access.fault ? access.index : fault_idx;
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      mode           <= dsgate_pkg::RUN_MODE;
      CLOCK_ENABLE_O <= '0;
      PERIPH_GRANT_O <= 1'b0;
      PERIPH_FAULT_O <= 1'b0;
      fault_idx      <= 4'h0;
    end else if (CE_I) begin
      mode           <= next_mode;
      CLOCK_ENABLE_O <= next_clock_enable;
      PERIPH_GRANT_O <= next_grant;
      PERIPH_FAULT_O <= next_fault;
      fault_idx      <= next_fault_idx;
    end
  end

  // --------------------------------------------------------------------
  // Interrupt status
  // --------------------------------------------------------------------
  always_comb begin
    int_set = '0;
    int_set[`DSG_INT_FAULT_BIT] = access.fault;
    int_set[`DSG_INT_SLEEP_BIT] = DEEP_SLEEP_I &&
                                  (mode == dsgate_pkg::RUN_MODE);
    // A new event wins over a clear in the same cycle
    next_int_stat = (int_stat & ~int_clr) | int_set;
    next_irq      = |(next_int_stat & next_int_en);
  end

  always_ff @(posedge CLOCK_I) begin
    if (SRST_I) begin
      int_stat <= '0;
      IRQ_O    <= 1'b0;
    end else if (CE_I) begin
      int_stat <= next_int_stat;
      IRQ_O    <= next_irq;
    end
  end

  // --------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (SRST_I);

  logic gate_wr;
  assign gate_wr = CE_I && wr_en && (addr == `DSG_GATE_OFFSET) &&
                   (PADDR_I[ADDR_WIDTH-1:0] == ADDR_WIDTH'(addr));

  timer_bits_a: assert property ( // [RULE_01]
    gate_wr |=> {ds_gate.gp_timer_three_clock_enable,
                 ds_gate.gp_timer_two_clock_enable,
                 ds_gate.gp_timer_one_clock_enable,
                 ds_gate.gp_timer_zero_clock_enable}
                == $past(PWDATA_I[19:16])
  ) else $error("timer gate bits not stored");

  comparator_bits_a: assert property ( // [RULE_02]
    gate_wr |=> {ds_gate.comparator_two_clock_enable,
                 ds_gate.comparator_one_clock_enable,
                 ds_gate.comparator_zero_clock_enable}
                == $past(PWDATA_I[26:24])
  ) else $error("comparator gate bits not stored");

  two_wire_bit_a: assert property ( // [RULE_03]
    gate_wr |=> ds_gate.two_wire_zero_clock_enable == $past(PWDATA_I[12])
  ) else $error("two-wire gate bit not stored");

  encoder_bit_a: assert property ( // [RULE_04]
    gate_wr |=> ds_gate.quadrature_encoder_clock_enable
                == $past(PWDATA_I[8])
  ) else $error("encoder gate bit not stored");

  sync_serial_a: assert property ( // [RULE_05]
    gate_wr |=> {ds_gate.sync_serial_one_clock_enable,
                 ds_gate.sync_serial_zero_clock_enable}
                == $past(PWDATA_I[5:4])
  ) else $error("sync serial gate bits not stored");

  clock_follow_a: assert property ( // [RULE_06]
    CE_I |=> CLOCK_ENABLE_O == $past(eff_gate)
  ) else $error("clock enable does not follow gate");

  fault_gated_a: assert property ( // [RULE_07]
    CE_I && PERIPH_REQ_I && |(PERIPH_SEL_I & ~eff_gate)
    |=> PERIPH_FAULT_O && !PERIPH_GRANT_O
  ) else $error("access to gated peripheral not faulted");

  reserved_zero_a: assert property ( // [RULE_08]
    CE_I && setup && !PWRITE_I && addr == `DSG_GATE_OFFSET
    |=> (PRDATA_O & ~`DSG_GATE_MASK) == 32'h0000_0000
  ) else $error("reserved bits read non-zero");

  gate_reset_a: assert property ( // [RULE_10]
    @(posedge CLOCK_I) disable iff (1'b0)
    SRST_I |=> ds_gate == '0 && CLOCK_ENABLE_O == '0
  ) else $error("gates not cleared by reset");

  sleep_select_a: assert property ( // [RULE_11]
    CE_I && mode == dsgate_pkg::DEEP_SLEEP_MODE && auto_clock_gating_select
    |=> CLOCK_ENABLE_O == $past(ds_gate)
  ) else $error("deep-sleep gates not applied");

  gate_readback_a: assert property ( // [RULE_12]
    CE_I && setup && !PWRITE_I && gate_wr == 1'b0 &&
    addr == `DSG_GATE_OFFSET && mapped
    |=> PRDATA_O == gate_to_reg($past(ds_gate))
  ) else $error("gate readback mismatch");

endmodule : deep_sleep_clock_gating

//--- tb/deep_sleep_clock_gating_test.sv
`timescale 1ns/1ps
`include "dsgate_params.svh"

module deep_sleep_clock_gating_test;

  localparam int LIMIT = 20000;

  typedef struct packed {
    logic [31:0] wdata;
    logic [31:0] rdata;
  } row_t;

  logic        clk        = 1'b0;
  logic        srst       = 1'b1;
  logic        ce         = 1'b1;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [11:0] paddr      = 12'h000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic        deep_sleep = 1'b0;
  logic        req        = 1'b0;
  logic [10:0] sel        = 11'h000;
  logic        pready;
  logic [31:0] prdata;
  logic        pslverr;
  logic        grant;
  logic        fault;
  logic        irq;
  dsgate_pkg::periph_gate_t clk_en;
  int          fail_count  = 0;
  int          checks_done = 0;
  int          cycles      = 0;
  logic [31:0] rd;
  logic        err;
  logic [10:0] eff;
  logic        grant_s;
  logic        fault_s;
  row_t        rows [8];

  deep_sleep_clock_gating u_dut (
    .CLOCK_I        (clk),
    .SRST_I         (srst),
    .CE_I           (ce),
    .PSEL_I         (psel),
    .PENABLE_I      (penable),
    .PWRITE_I       (pwrite),
    .PADDR_I        (paddr),
    .PWDATA_I       (pwdata),
    .PREADY_O       (pready),
    .PRDATA_O       (prdata),
    .PSLVERR_O      (pslverr),
    .DEEP_SLEEP_I   (deep_sleep),
    .PERIPH_REQ_I   (req),
    .PERIPH_SEL_I   (sel),
    .PERIPH_GRANT_O (grant),
    .PERIPH_FAULT_O (fault),
    .CLOCK_ENABLE_O (clk_en),
    .IRQ_O          (irq)
  );

  // ----------------------------------------------------------------------
  // Clock and cycle limit
  // ----------------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == LIMIT) begin
      fail_count++;
      test_done();
    end
  end

  // ----------------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // Expected enable vector: comparator two at the top, sync serial zero last
  function automatic logic [10:0] pack(input logic [31:0] w);
    return {w[26:24], w[19:16], w[12], w[8], w[5:4]};
  endfunction : pack

  task automatic apb(input logic wr, input logic [11:0] a,
                     input logic [31:0] wd, output logic [31:0] rdat,
                     output logic slverr);
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rdat   = prdata;
    slverr = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr_reg(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] dummy;
    logic        e;
    apb(1'b1, a, d, dummy, e);
    check({31'h0, e}, 32'h0000_0000);
  endtask : wr_reg

  task automatic rd_reg(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    logic        e;
    apb(1'b0, a, 32'h0000_0000, v, e);
    check(v, exp);
    check({31'h0, e}, 32'h0000_0000);
  endtask : rd_reg

  task automatic poke(input logic [10:0] s, output logic g, output logic f);
    @(posedge clk);
    req <= 1'b1;
    sel <= s;
    @(posedge clk);
    req <= 1'b0;
    @(posedge clk);
    g = grant;
    f = fault;
  endtask : poke

  task automatic settle();
    repeat (3) @(posedge clk);
  endtask : settle

  task automatic test_done();
    $display("checks %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done

  // ----------------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------------
  initial begin
    rows[0] = '{32'hFFFF_FFFF, 32'h070F_1130};
    rows[1] = '{32'h0700_0000, 32'h0700_0000};
    rows[2] = '{32'h000F_0000, 32'h000F_0000};
    rows[3] = '{32'h0000_1000, 32'h0000_1000};
    rows[4] = '{32'h0000_0100, 32'h0000_0100};
    rows[5] = '{32'h0000_0030, 32'h0000_0030};
    rows[6] = '{32'hF8F0_EEC0, 32'h0000_0000};
    rows[7] = '{32'h0400_0010, 32'h0400_0010};
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    #1;
    check({21'h0, clk_en}, 32'h0000_0000);
    rd_reg(`DSG_GATE_OFFSET, `DSG_GATE_RESET);
    rd_reg(`DSG_RUN_OFFSET, 32'h0000_0000);
    $display("done: reset values");

    foreach (rows[i]) begin
      wr_reg(`DSG_GATE_OFFSET, rows[i].wdata);
      rd_reg(`DSG_GATE_OFFSET, rows[i].rdata);
    end
    $display("done: gate field table");

    // Read-modify-write that keeps the reserved bits as read
    apb(1'b0, `DSG_GATE_OFFSET, 32'h0000_0000, rd, err);
    wr_reg(`DSG_GATE_OFFSET, rd | 32'h0002_0000);
    rd_reg(`DSG_GATE_OFFSET, 32'h0402_0010);
    $display("done: read-modify-write");

    // Run gate in force until deep-sleep with auto gating
    wr_reg(`DSG_GATE_OFFSET, 32'h050A_1020);
    wr_reg(`DSG_RUN_OFFSET, 32'h0205_0110);
    deep_sleep <= 1'b1;
    settle();
    check({21'h0, clk_en}, {21'h0, pack(32'h0205_0110)});
    wr_reg(`DSG_CONFIG_OFFSET, 32'h0000_0001);
    settle();
    check({21'h0, clk_en}, {21'h0, pack(32'h050A_1020)});
    deep_sleep <= 1'b0;
    settle();
    check({21'h0, clk_en}, {21'h0, pack(32'h0205_0110)});
    deep_sleep <= 1'b1;
    settle();
    $display("done: clock enable selection");

    // Every peripheral in turn against the deep-sleep gates
    eff = pack(32'h050A_1020);
    wr_reg(`DSG_INT_CLR_OFFSET, 32'h0000_0003);
    rd_reg(`DSG_INT_STAT_OFFSET, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      poke(11'h001 << i, grant_s, fault_s);
      check({30'h0, grant_s, fault_s}, {30'h0, eff[i], ~eff[i]});
      if (!eff[i]) rd_reg(`DSG_FAULT_OFFSET, 32'(i));
    end
    poke(11'h000, grant_s, fault_s);
    check({30'h0, grant_s, fault_s}, 32'h0000_0000);
    $display("done: peripheral access");

    // Clock enable low freezes the enables and ignores requests
    ce         <= 1'b0;
    deep_sleep <= 1'b0;
    settle();
    check({21'h0, clk_en}, {21'h0, eff});
    poke(11'h001, grant_s, fault_s);
    check({30'h0, grant_s, fault_s}, 32'h0000_0000);
    deep_sleep <= 1'b1;
    ce         <= 1'b1;
    $display("done: clock enable freeze");

    // Interrupt masked, then enabled, then cleared
    check({31'h0, irq}, 32'h0000_0000);
    rd_reg(`DSG_INT_STAT_OFFSET, 32'h0000_0001);
    wr_reg(`DSG_INT_STAT_OFFSET, 32'h0000_0000);
    wr_reg(`DSG_INT_EN_OFFSET, 32'h0000_0001);
    settle();
    check({31'h0, irq}, 32'h0000_0001);
    rd_reg(`DSG_INT_CLR_OFFSET, 32'h0000_0000);
    wr_reg(`DSG_INT_CLR_OFFSET, 32'h0000_0001);
    settle();
    check({31'h0, irq}, 32'h0000_0000);
    rd_reg(`DSG_INT_STAT_OFFSET, 32'h0000_0000);
    $display("done: interrupt");

    // Unmapped addresses answer with an error and hold no state
    apb(1'b0, 12'h300, 32'h0000_0000, rd, err);
    check(rd, 32'h0000_0000);
    check({31'h0, err}, 32'h0000_0001);
    apb(1'b1, 12'h0FC, 32'hFFFF_FFFF, rd, err);
    check({31'h0, err}, 32'h0000_0001);
    rd_reg(`DSG_GATE_OFFSET, 32'h050A_1020);
    $display("done: unmapped access");

    // Reset in mid-run clears every gate
    @(posedge clk);
    srst <= 1'b1;
    @(posedge clk);
    srst <= 1'b0;
    #1;
    check({21'h0, clk_en}, 32'h0000_0000);
    rd_reg(`DSG_GATE_OFFSET, 32'h0000_0000);
    $display("done: second reset");
    test_done();
  end

endmodule : deep_sleep_clock_gating_test
